// ---- hw/mflm_top.sv ----
module mflm_top (
    input wire logic clk,
    input wire logic nrst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    output logic [15:0] max_frame_len,
    output logic mdc,
    output logic mdio_out,
    output logic mdio_oe,
    input wire logic mdio_in
);
    typedef struct packed {
        logic        dp_valid;
        logic        dp_write;
        logic [11:0] dp_addr;
        logic [2:0]  dp_size;
        logic [15:0] maxf;
        logic [15:0] mgmt_write_word;
        logic [15:0] mgmt_read_word;
        logic [15:0] mgmt_phy_reg_address;
        logic [15:0] cmd;
        logic        launch;
        logic [31:0] rdata;
    } mflm_top_state_t;

    mflm_top_state_t s;
    mflm_top_state_t next_s;
    mflm_pkg::mflm_mgmt_req_t req;
    mflm_pkg::mflm_mgmt_rsp_t rsp;
    mflm_pkg::mflm_mdio_pins_t pins;
    logic [15:0] wr_half;
    logic [1:0] lanes;
    logic [15:0] cur_val;
    logic [15:0] new_val;
    logic [11:0] reg_base;
    logic [3:0] alias_sel;
    logic [11:0] ap_base;
    logic addr_ok;
    logic size_ok;

    // data phase decode; ap_base decodes the address phase for reads
    assign reg_base = {s.dp_addr[11:4], 4'h0};
    assign alias_sel = {s.dp_addr[3:2], 2'b00};
    assign ap_base = {haddr[11:4], 4'h0};
    // byte writes are dropped; upper half of a word never stored
    assign size_ok = (s.dp_size == 3'b001) || (s.dp_size == 3'b010);
    assign wr_half = (s.dp_size == 3'b001 && s.dp_addr[1]) ? hwdata[31:16] : hwdata[15:0];
    assign lanes = (s.dp_size == 3'b001 && s.dp_addr[1]) ? 2'b00 : 2'b11;

    always_comb
    begin
        addr_ok = 1'b1;
        case (reg_base)
            mflm_pkg::MFLM_OFS_MAXF: cur_val = s.maxf;
            mflm_pkg::MFLM_OFS_MADR: cur_val = s.mgmt_phy_reg_address;
            mflm_pkg::MFLM_OFS_MCMD: cur_val = s.cmd;
            mflm_pkg::MFLM_OFS_MGMT_WRITE_WORD: cur_val = s.mgmt_write_word;
            mflm_pkg::MFLM_OFS_MGMT_READ_WORD: cur_val = s.mgmt_read_word;
            mflm_pkg::MFLM_OFS_MIND: cur_val = {15'h0000, rsp.busy};
            default:
            begin
                cur_val = mflm_pkg::MFLM_ZERO16;
                addr_ok = 1'b0;
            end
        endcase
    end

    mflm_alias_unit u_alias (
        .cur(cur_val),
        .wdata(wr_half),
        .lanes(lanes),
        .alias_sel(alias_sel),
        .result(new_val)
    );

    always_comb
    begin
        next_s = s;
        next_s.launch = 1'b0;
        if (hready)
        begin
            next_s.dp_valid = hsel && htrans[1];
            next_s.dp_write = hwrite;
            next_s.dp_addr = haddr[11:0];
            next_s.dp_size = hsize;
        end
        if (s.dp_valid && s.dp_write && size_ok && addr_ok)
        begin
            case (reg_base)
                mflm_pkg::MFLM_OFS_MAXF: next_s.maxf = new_val;
                mflm_pkg::MFLM_OFS_MADR: next_s.mgmt_phy_reg_address = new_val;
                mflm_pkg::MFLM_OFS_MCMD:
                begin
                    next_s.cmd = new_val;
                    // any write that leaves the read bit set starts a read cycle; ignored while busy
                    if (new_val[mflm_pkg::MFLM_CMD_READ_POS] && !rsp.busy)
                        next_s.launch = 1'b1;
                end
                mflm_pkg::MFLM_OFS_MGMT_WRITE_WORD:
                begin
                    next_s.mgmt_write_word = new_val;
                    next_s.cmd[mflm_pkg::MFLM_CMD_READ_POS] = 1'b0;
                    next_s.launch = !rsp.busy;
                end
                mflm_pkg::MFLM_OFS_MGMT_READ_WORD: next_s.mgmt_read_word = new_val;
                default: next_s.launch = 1'b0;
            endcase
        end
        // hardware update beats a same-cycle software write
        if (rsp.done && s.cmd[mflm_pkg::MFLM_CMD_READ_POS])
            next_s.mgmt_read_word = rsp.rdata;
        // loaded at the address edge so it stands in the data phase; next_s forwards writes
        if (hready && hsel && htrans[1] && !hwrite)
        begin
            case (ap_base)
                mflm_pkg::MFLM_OFS_MAXF: next_s.rdata = {16'h0000, next_s.maxf};
                mflm_pkg::MFLM_OFS_MADR: next_s.rdata = {16'h0000, next_s.mgmt_phy_reg_address};
                mflm_pkg::MFLM_OFS_MCMD: next_s.rdata = {16'h0000, next_s.cmd};
                mflm_pkg::MFLM_OFS_MGMT_WRITE_WORD: next_s.rdata = {16'h0000, next_s.mgmt_write_word};
                mflm_pkg::MFLM_OFS_MGMT_READ_WORD: next_s.rdata = {16'h0000, next_s.mgmt_read_word};
                mflm_pkg::MFLM_OFS_MIND:
                    next_s.rdata = {16'h0000, 15'h0000, rsp.busy | s.launch | next_s.launch};
                default: next_s.rdata = 32'h00000000;
            endcase
            // upper half reads as zero
            if (haddr[1])
                next_s.rdata = 32'h00000000;
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            s <= '0;
            s.maxf <= mflm_pkg::MFLM_MAXF_RESET;
        end
        else
            s <= next_s;
    end

    always_comb
    begin
        req.go = s.launch;
        req.read = s.cmd[mflm_pkg::MFLM_CMD_READ_POS];
        req.phy = s.mgmt_phy_reg_address[mflm_pkg::MFLM_ADDR_PHY_POS +: 5];
        req.reg_addr = s.mgmt_phy_reg_address[mflm_pkg::MFLM_ADDR_REG_POS +: 5];
        req.wdata = s.mgmt_write_word;
    end

    mflm_mdio_master u_mdio (
        .clk(clk),
        .nrst(nrst),
        .req(req),
        .rsp(rsp),
        .pins(pins),
        .mdio_in(mdio_in)
    );

    // outputs come from single flops or constants; pins come from flops inside the serial engine
    assign hrdata = s.rdata;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign max_frame_len = s.maxf;
    assign mdc = pins.mdc;
    assign mdio_out = pins.mdio_out;
    assign mdio_oe = pins.mdio_oe;
endmodule

// ---- common/mflm_pkg.sv ----
// Contract
// - frame length field resets to 1518 octets, value 0x05EE
// - writable 16-bit frame length limit drives the receive path restriction
// - upper sixteen bits of all three registers read as zero
// - 16/32-bit accesses allowed incl. set/clear/invert; byte writes ignored
// - writing write-data register launches management write with held addresses
// - completed management read places PHY data into read-data register
// - management interface configures and queries the external PHY
package mflm_pkg;
    localparam logic [11:0] MFLM_OFS_MAXF = 12'h000;
    localparam logic [11:0] MFLM_OFS_MADR = 12'h010;
    localparam logic [11:0] MFLM_OFS_MCMD = 12'h020;
    localparam logic [11:0] MFLM_OFS_MGMT_WRITE_WORD = 12'h030;
    localparam logic [11:0] MFLM_OFS_MGMT_READ_WORD = 12'h040;
    localparam logic [11:0] MFLM_OFS_MIND = 12'h050;
    localparam logic [3:0] MFLM_ALIAS_CLR = 4'h4;
    localparam logic [3:0] MFLM_ALIAS_SET = 4'h8;
    localparam logic [3:0] MFLM_ALIAS_INV = 4'hC;
    localparam logic [15:0] MFLM_MAXF_RESET = 16'h05EE;
    localparam logic [15:0] MFLM_ZERO16 = 16'h0000;
    localparam int MFLM_ADDR_REG_POS = 0;
    localparam int MFLM_ADDR_PHY_POS = 8;
    localparam int MFLM_CMD_READ_POS = 0;
    localparam int MFLM_IND_BUSY_POS = 0;
    localparam int MFLM_MDC_DIV = 10;
    localparam int MFLM_FRAME_BITS = 64;
    localparam int MFLM_PREAMBLE_BITS = 32;
    localparam int MFLM_TA_FIRST = 46;
    localparam int MFLM_DATA_FIRST = 48;

    typedef struct packed {
        logic        go;
        logic        read;
        logic [4:0]  phy;
        logic [4:0]  reg_addr;
        logic [15:0] wdata;
    } mflm_mgmt_req_t;

    typedef struct packed {
        logic        done;
        logic        busy;
        logic [15:0] rdata;
    } mflm_mgmt_rsp_t;

    typedef struct packed {
        logic mdc;
        logic mdio_out;
        logic mdio_oe;
    } mflm_mdio_pins_t;
endpackage

// ---- hw/mflm_mdio_master.sv ----
module mflm_mdio_master (
    input wire logic clk,
    input wire logic nrst,
    input wire mflm_pkg::mflm_mgmt_req_t req,
    output mflm_pkg::mflm_mgmt_rsp_t rsp,
    output mflm_pkg::mflm_mdio_pins_t pins,
    input wire logic mdio_in
);
    typedef struct packed {
        logic        active;
        logic        read;
        logic [7:0]  div;
        logic [6:0]  bit_idx;
        logic [31:0] shift;
        logic [15:0] rdata;
        logic        done;
        logic        mdc;
        logic        mdio_out;
        logic        mdio_oe;
    } mflm_mdio_state_t;

    localparam logic [7:0] DIV_LAST = 8'(mflm_pkg::MFLM_MDC_DIV - 1);
    localparam logic [6:0] BITS_LAST = 7'(mflm_pkg::MFLM_FRAME_BITS - 1);
    localparam logic [6:0] PRE_BITS = 7'(mflm_pkg::MFLM_PREAMBLE_BITS);
    localparam logic [6:0] TA_FIRST = 7'(mflm_pkg::MFLM_TA_FIRST);
    localparam logic [6:0] DATA_FIRST = 7'(mflm_pkg::MFLM_DATA_FIRST);

    mflm_mdio_state_t s;
    mflm_mdio_state_t next_s;

    always_comb
    begin
        next_s = s;
        next_s.done = 1'b0;
        if (!s.active)
        begin
            if (req.go)
            begin
                // start, opcode, phy, reg, turnaround, data
                next_s.active = 1'b1;
                next_s.read = req.read;
                next_s.div = 8'h00;
                next_s.bit_idx = 7'h00;
                next_s.shift = {2'b01, req.read ? 2'b10 : 2'b01, req.phy, req.reg_addr,
                    2'b10, req.wdata};
                next_s.mdio_oe = 1'b1;
                next_s.mdio_out = 1'b1;
                next_s.mdc = 1'b0;
            end
        end
        else if (s.div == DIV_LAST)
        begin
            // falling edge of mdc: present next bit; phy samples on rising
            next_s.div = 8'h00;
            next_s.mdc = 1'b0;
            if (s.bit_idx == BITS_LAST)
            begin
                next_s.active = 1'b0;
                next_s.mdio_oe = 1'b0;
                next_s.done = 1'b1;
            end
            else
            begin
                next_s.bit_idx = s.bit_idx + 7'h01;
                if (s.bit_idx + 7'h01 >= PRE_BITS)
                begin
                    next_s.mdio_out = s.shift[31];
                    next_s.shift = {s.shift[30:0], 1'b0};
                end
                // release the line for turnaround and data on reads
                next_s.mdio_oe = !(s.read && (s.bit_idx + 7'h01 >= TA_FIRST));
            end
        end
        else
        begin
            next_s.div = s.div + 8'h01;
            if (s.div == 8'(mflm_pkg::MFLM_MDC_DIV / 2 - 1))
            begin
                next_s.mdc = 1'b1;
                if (s.read && s.bit_idx >= DATA_FIRST)
                    next_s.rdata = {s.rdata[14:0], mdio_in};
            end
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            s <= '0;
        else
            s <= next_s;
    end

    assign rsp.done = s.done;
    assign rsp.busy = s.active;
    assign rsp.rdata = s.rdata;
    assign pins.mdc = s.mdc;
    assign pins.mdio_out = s.mdio_out;
    assign pins.mdio_oe = s.mdio_oe;
endmodule

// ---- hw/mflm_alias_unit.sv ----
module mflm_alias_unit (
    input wire logic [15:0] cur,
    input wire logic [15:0] wdata,
    input wire logic [1:0] lanes,
    input wire logic [3:0] alias_sel,
    output logic [15:0] result
);
    logic [15:0] merged;
    logic [15:0] mask;

    always_comb
    begin
        mask = {{8{lanes[1]}}, {8{lanes[0]}}};
        case (alias_sel)
            mflm_pkg::MFLM_ALIAS_CLR: merged = cur & ~wdata;
            mflm_pkg::MFLM_ALIAS_SET: merged = cur | wdata;
            mflm_pkg::MFLM_ALIAS_INV: merged = cur ^ wdata;
            default: merged = wdata;
        endcase
        result = (merged & mask) | (cur & ~mask);
    end
endmodule

// ---- tb/mflm_phy_model.sv ----
module mflm_phy_model (
    input wire logic mdc,
    input wire logic mdio_out,
    input wire logic mdio_oe,
    input wire logic [15:0] rd_val,
    output logic mdio_in,
    output logic [31:0] frame
);
    timeunit 1ns;
    timeprecision 1ns;
    logic drv = 1'b0;
    logic dbit = 1'b1;
    logic act = 1'b0;
    logic rd = 1'b0;
    logic [31:0] sr = 32'h0;
    int k = 0;
    // released line rests high through the pull-up
    assign mdio_in = mdio_oe ? mdio_out : (drv ? dbit : 1'b1);
    // sample on mdc rise, frame opens after preamble ones and start bits
    always @(posedge mdc)
    begin
        sr = {sr[30:0], mdio_in};
        k = k + 1;
        // last 30 preamble ones demanded, so stale data bits cannot fake a start
        if (!act && sr == 32'hFFFFFFFD)
        begin
            act = 1'b1;
            k = 0;
        end
        if (k == 2)
            rd = act && sr[1:0] == 2'h2;
        if (act && k == 30)
        begin
            frame = sr;
            act = 1'b0;
        end
    end
    // turnaround low, then data msb first, changed on mdc fall
    always @(negedge mdc)
    begin
        drv = act && rd && k >= 13 && k <= 29;
        dbit = k == 13 ? 1'b0 : rd_val[29 - k];
    end
endmodule

// ---- tb/mflm_top_checker.sv ----
module mflm_top_checker (
    input wire logic clk,
    input wire logic nrst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [15:0] max_frame_len,
    input wire logic mdc,
    input wire logic mdio_out,
    input wire logic mdio_oe
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);
    logic tk;
    logic bw;
    logic wd;
    assign tk = hsel && hready && htrans[1];
    // flags mark the data phase of the transfer taken one edge before
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            bw <= 1'b0;
            wd <= 1'b0;
        end
        else
        begin
            bw <= tk && hwrite && hsize == 3'h0;
            wd <= tk && hwrite && hsize != 3'h0 && haddr[11:0] == mflm_pkg::MFLM_OFS_MGMT_WRITE_WORD;
        end
    end
    property p_okay; hreadyout && !hresp; endproperty
    a_okay: assert property (p_okay) else $error("bus not ready or not okay");
    property p_maxf_rst; !$past(nrst) |-> max_frame_len == 16'h05EE; endproperty
    a_maxf_rst: assert property (p_maxf_rst) else $error("length reset value");
    property p_byte_ign; bw |=> $stable(max_frame_len); endproperty
    a_byte_ign: assert property (p_byte_ign) else $error("byte write took effect");
    property p_upper; hrdata[31:16] == 16'h0000; endproperty
    a_upper: assert property (p_upper) else $error("upper read bits set");
    property p_launch; wd && !mdio_oe && !mdc |-> ##[1:3] $rose(mdio_oe); endproperty
    a_launch: assert property (p_launch) else $error("write cycle not launched");
    property p_preamble; $rose(mdio_oe) |-> mdio_out; endproperty
    a_preamble: assert property (p_preamble) else $error("frame not opened by ones");
    property p_mdc; $rose(mdc) |-> mdc [*5] ##1 !mdc [*5]; endproperty
    a_mdc: assert property (p_mdc) else $error("mdc period wrong");
    property p_bit_edge;
        mdio_oe && $past(mdio_oe) && $changed(mdio_out) |-> !mdc && $past(mdc);
    endproperty
    a_bit_edge: assert property (p_bit_edge) else $error("data moved off mdc fall");
    c_launch: cover property (wd);
    c_byte: cover property (bw);
    c_frame_end: cover property ($fell(mdio_oe));
endmodule

bind mflm_top mflm_top_checker i_chk (.clk, .nrst, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hready, .hrdata, .hreadyout, .hresp, .max_frame_len, .mdc, .mdio_out, .mdio_oe);

// ---- tb/mac_frame_limit_and_mgmt_data_tb.sv ----
module mac_frame_limit_and_mgmt_data_tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [11:0] MX = mflm_pkg::MFLM_OFS_MAXF;
    localparam logic [11:0] MR = mflm_pkg::MFLM_OFS_MGMT_READ_WORD;
    localparam logic [11:0] MA = mflm_pkg::MFLM_OFS_MADR;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata, r, frame;
    logic hreadyout, hresp, mdc, mdio_out, mdio_oe, mdio_in;
    logic [15:0] max_frame_len;
    logic [15:0] rd_val = 16'hC3A5;
    int error_cnt = 0;
    int checks = 0;
    // rows: write flag, offset, size, write data or expected read data
    logic [47:0] rows [16] = '{{1'h1, MX, 3'h2, 32'hABCD05F2},
        {1'h0, MX, 3'h2, 32'h5F2}, {1'h1, MX, 3'h1, 32'h5F7},
        {1'h1, MX, 3'h0, 32'hFF}, {1'h0, MX, 3'h2, 32'h5F7},
        {1'h1, MX + 12'h8, 3'h2, 32'h8}, {1'h0, MX, 3'h2, 32'h5FF},
        {1'h1, MX + 12'h4, 3'h1, 32'hF0}, {1'h0, MX, 3'h2, 32'h50F},
        {1'h1, MX + 12'hC, 3'h2, 32'hFFFF}, {1'h0, MX, 3'h1, 32'hFAF0},
        {1'h1, MR, 3'h2, 32'h1234}, {1'h0, MR, 3'h2, 32'h1234},
        {1'h1, MA, 3'h2, 32'h1105}, {1'h0, MA, 3'h2, 32'h1105},
        {1'h0, 12'h0F0, 3'h2, 32'h0}};
    mflm_top i_dut (.clk, .nrst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hrdata, .hreadyout, .hresp, .max_frame_len, .mdc,
        .mdio_out, .mdio_oe, .mdio_in);
    mflm_phy_model i_phy (.mdc, .mdio_out, .mdio_oe, .rd_val, .mdio_in, .frame);
    initial
        forever #20 clk = ~clk;
    task automatic tally_and_finish;
        $display("errors %0d checks %0d", error_cnt, checks);
        if (error_cnt == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic edge_rdy;
        int n;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (hreadyout !== 1'b1 && n < 20);
        if (hreadyout !== 1'b1)
        begin
            error_cnt++;
            $display("mismatch at %0t: bus ready timeout", $time);
            tally_and_finish();
        end
    endtask
    task automatic xfer(input logic [47:0] t);
        hsel <= 1'b1;
        haddr <= {20'h0, t[46:35]};
        htrans <= 2'h2;
        hwrite <= t[47];
        hsize <= t[34:32];
        edge_rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= t[31:0];
        edge_rdy();
        r = hrdata;
    endtask
    // busy polling keeps the bus active while a frame runs
    task automatic wait_idle;
        int n;
        n = 0;
        repeat (2) @(posedge clk);
        do
        begin
            xfer({1'h0, mflm_pkg::MFLM_OFS_MIND, 3'h2, 32'h0});
            n++;
        end
        while (r[0] !== 1'b0 && n < 400);
        if (r[0] !== 1'b0)
        begin
            error_cnt++;
            $display("mismatch at %0t: management cycle timeout", $time);
            tally_and_finish();
        end
    endtask
    initial
    begin
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        chk({16'h0, max_frame_len}, 32'h5EE);
        foreach (rows[i])
        begin
            xfer(rows[i]);
            if (!rows[i][47])
                chk(r, rows[i][31:0]);
            if (!rows[i][47] && rows[i][46:35] == MX)
                chk({16'h0, max_frame_len}, rows[i][31:0]);
        end
        xfer({1'h1, mflm_pkg::MFLM_OFS_MGMT_WRITE_WORD, 3'h0, 32'h1});
        repeat (4) @(posedge clk);
        chk({31'h0, mdio_oe}, 32'h0);
        xfer({1'h1, mflm_pkg::MFLM_OFS_MGMT_WRITE_WORD, 3'h2, 32'h5A5ABEEF});
        wait_idle();
        chk(frame, {4'h5, 5'h11, 5'h05, 2'h2, 16'hBEEF});
        xfer({1'h1, mflm_pkg::MFLM_OFS_MCMD, 3'h2, 32'h1});
        wait_idle();
        chk(frame[31:16], {4'h6, 5'h11, 5'h05, 2'h2});
        xfer({1'h0, MR, 3'h2, 32'h0});
        chk(r, 32'h0000C3A5);
        nrst <= 1'b0;
        repeat (2) @(posedge clk);
        chk({16'h0, max_frame_len}, 32'h5EE);
        nrst <= 1'b1;
        @(posedge clk);
        xfer({1'h0, MX, 3'h2, 32'h0});
        chk(r, 32'h000005EE);
        tally_and_finish();
    end
endmodule
